// ### mrd_pkg.sv
// constants for the move and return instruction decoder
// assumes 14-bit instruction words and an 8-bit data path
package mrd_pkg;
   localparam int IW = 14;
   localparam int DW = 8;
   localparam int PW = 11;
   localparam logic [5:0] OPH_FILE_TO_ACC   = 6'h08;
   localparam logic [5:0] OPH_LIT_TO_ACC    = 6'h19;
   localparam logic [5:0] OPH_RET_LIT       = 6'h18;
   localparam logic [5:0] OPH_ACC_TO_EXT    = 6'h1E;
   localparam logic [5:0] OPH_EXT_TO_ACC    = 6'h1F;
   localparam logic [13:0] OP_IDLE_WORD     = 14'h0000;
   localparam logic [13:0] OP_INT_RET_WORD  = 14'h0060;
   localparam logic [7:0] EXT_READ_LOW      = 8'h20;
   localparam logic [7:0] ACC_RESET         = 8'h00;
   localparam logic [10:0] PC_RESET         = 11'h000;
   localparam int RET_CYCLES                = 2;
   localparam int STACK_DEPTH               = 8;
   localparam int SP_W                      = 3;
endpackage

// ### mrd_core.sv
// move and return instruction decoder with accumulator, pc and return stack
// assumes instructions are presented one per cycle with instr_valid, and that
// file/extended register data arrive combinationally on rd_data
`timescale 1ns/1ps
`default_nettype none

module mrd_core #(
   parameter int PW    = mrd_pkg::PW,
   parameter int DEPTH = mrd_pkg::STACK_DEPTH
) (
   // clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rst,
   // instruction fetch
   input  wire logic [mrd_pkg::IW-1:0] instr,
   input  wire logic                   instr_valid,
   output logic                        instr_ready,
   output logic [PW-1:0]               pc,
   // register file access
   output logic [7:0]                  reg_addr,
   output logic                        reg_ext,
   output logic                        reg_rd,
   output logic                        reg_wr,
   output logic [mrd_pkg::DW-1:0]      reg_wdata,
   input  wire logic [mrd_pkg::DW-1:0] rd_data,
   // call side of the return stack, interrupt enable, accumulator and range error
   input  wire logic                   push,
   input  wire logic [PW-1:0]          push_addr,
   input  wire logic                   ien_clear,
   output logic                        global_interrupt_enable,
   output logic [mrd_pkg::DW-1:0]      acc,
   output logic                        ext_range_err
);
   typedef enum logic [0:0] {MRD_EXEC, MRD_FLUSH} mrd_state_t;

   // instruction sequencing
   mrd_state_t               state_q;
   mrd_state_t               state_d;
   logic                     ready_q;
   logic [PW-1:0]            pc_q;
   logic [PW-1:0]            pc_d;
   // accumulator and interrupt enable
   logic [mrd_pkg::DW-1:0]   acc_q;
   logic [mrd_pkg::DW-1:0]   acc_d;
   logic                     ien_q;
   logic                     ien_d;
   // return stack
   logic [PW-1:0]            stack_q [DEPTH];
   logic [mrd_pkg::SP_W-1:0] sp_q;
   logic [mrd_pkg::SP_W-1:0] sp_d;
   // register file strobes, one cycle after the instruction
   logic [7:0]               addr_q;
   logic [7:0]               addr_d;
   logic                     ext_q;
   logic                     rd_q;
   logic                     wr_q;
   logic                     err_q;
   logic [mrd_pkg::DW-1:0]   wdata_q;

   // file space is 7 bits wide, zero-extended onto the shared address
   function automatic logic [7:0] file_addr(input logic [mrd_pkg::IW-1:0] w);
      return {1'b0, w[6:0]};
   endfunction

   // extended reads below the floor are refused and acc is kept
   function automatic logic ext_below_floor(input logic [7:0] a);
      return a < mrd_pkg::EXT_READ_LOW;
   endfunction

   wire logic       take = instr_valid && (state_q == MRD_EXEC);
   wire logic [5:0] oph  = instr[13:8];
   wire logic [7:0] lit  = instr[7:0];
   wire logic       is_f2a  = take && oph == mrd_pkg::OPH_FILE_TO_ACC && !instr[7];
   wire logic       is_l2a  = take && oph == mrd_pkg::OPH_LIT_TO_ACC;
   wire logic       is_a2f  = take && oph == 6'h00 && instr[7];
   wire logic       is_a2e  = take && oph == mrd_pkg::OPH_ACC_TO_EXT;
   wire logic       is_e2a  = take && oph == mrd_pkg::OPH_EXT_TO_ACC;
   wire logic       is_iret = take && instr == mrd_pkg::OP_INT_RET_WORD;
   wire logic       is_retl = take && oph == mrd_pkg::OPH_RET_LIT;
   wire logic       is_ret  = is_iret || is_retl;
   wire logic [mrd_pkg::SP_W-1:0] sp_top = sp_q - 1'b1;
   wire logic [PW-1:0] stack_top_entry = stack_q[sp_top];

   always_comb begin
      state_d = MRD_EXEC;
      pc_d    = pc_q;
      acc_d   = acc_q;
      ien_d   = ien_q;
      sp_d    = sp_q;
      addr_d  = 8'h00;
      if (take) begin
         pc_d = pc_q + 1'b1;
      end
      if (is_f2a) begin
         acc_d = rd_data;
      end
      if (is_l2a || is_retl) begin
         acc_d = lit;
      end
      if (is_e2a && !ext_below_floor(lit)) begin
         acc_d = rd_data;
      end
      if (is_ret) begin
         pc_d    = stack_top_entry;
         sp_d    = sp_top;
         state_d = MRD_FLUSH;
      end
      if (is_iret) begin
         ien_d = 1'b1;
      end else if (ien_clear) begin
         ien_d = 1'b0;
      end
      if (push && !is_ret) begin
         sp_d = sp_q + 1'b1;
      end
      if (is_f2a || is_a2f) begin
         addr_d = file_addr(instr);
      end else if (is_a2e || is_e2a) begin
         addr_d = lit;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= MRD_EXEC;
         ready_q <= 1'b1;
         pc_q    <= mrd_pkg::PC_RESET;
         acc_q   <= mrd_pkg::ACC_RESET;
         ien_q   <= 1'b0;
         sp_q    <= '0;
      end else begin
         state_q <= state_d;
         ready_q <= state_d == MRD_EXEC;
         pc_q    <= pc_d;
         acc_q   <= acc_d;
         ien_q   <= ien_d;
         sp_q    <= sp_d;
      end
   end

   // stack contents need no reset; underflow simply wraps around
   always_ff @(posedge mclk) begin
      if (push && !is_ret) begin
         stack_q[sp_q] <= push_addr;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         addr_q  <= 8'h00;
         ext_q   <= 1'b0;
         rd_q    <= 1'b0;
         wr_q    <= 1'b0;
         wdata_q <= '0;
         err_q   <= 1'b0;
      end else begin
         addr_q  <= addr_d;
         ext_q   <= is_a2e || is_e2a;
         rd_q    <= is_f2a || is_e2a;
         wr_q    <= is_a2f || is_a2e;
         wdata_q <= acc_q;
         err_q   <= is_e2a && ext_below_floor(lit);
      end
   end

   // every output is a flop; read data must still arrive in the word's own cycle
   assign instr_ready             = ready_q;
   assign pc                      = pc_q;
   assign acc                     = acc_q;
   assign global_interrupt_enable = ien_q;
   assign reg_addr                = addr_q;
   assign reg_ext                 = ext_q;
   assign reg_rd                  = rd_q;
   assign reg_wr                  = wr_q;
   assign reg_wdata               = wdata_q;
   assign ext_range_err           = err_q;

   // all checks are muted while rst is high
   AST_L2A: assert property (@(posedge mclk) disable iff (rst)
      is_l2a |=>
      acc_q == $past(lit))
      else $error("literal not loaded");

   AST_F2A: assert property (@(posedge mclk) disable iff (rst)
      is_f2a |=>
      acc_q == $past(rd_data))
      else $error("file read lost");

   AST_A2F: assert property (@(posedge mclk) disable iff (rst)
      is_a2f |=>
      reg_wr && !reg_ext && reg_addr == file_addr($past(instr)))
      else $error("file write wrong");

   AST_A2E: assert property (@(posedge mclk) disable iff (rst)
      is_a2e |=>
      reg_wr && reg_ext && reg_wdata == $past(acc_q))
      else $error("ext write wrong");

   AST_E2A: assert property (@(posedge mclk) disable iff (rst)
      is_e2a && ext_below_floor(lit) |=>
      acc_q == $past(acc_q) && ext_range_err)
      else $error("bad ext read taken");

   AST_RET2: assert property (@(posedge mclk) disable iff (rst)
      is_ret |=>
      !instr_ready ##1 instr_ready)
      else $error("return not two cycles");

   AST_GIE: assert property (@(posedge mclk) disable iff (rst)
      is_iret |=>
      global_interrupt_enable)
      else $error("interrupt enable not set");

   AST_POP: assert property (@(posedge mclk) disable iff (rst)
      is_ret && !push |=>
      sp_q == $past(sp_q) - 3'h1)
      else $error("no pop");

   AST_RPC: assert property (@(posedge mclk) disable iff (rst)
      is_retl |=>
      pc_q == $past(stack_top_entry))
      else $error("pc not restored");

   AST_IDLE: assert property (@(posedge mclk) disable iff (rst)
      take && instr == mrd_pkg::OP_IDLE_WORD |=>
      pc_q == $past(pc_q) + 1'b1 && acc_q == $past(acc_q) && !reg_wr)
      else $error("idle changed state");

   AST_IRET_PC: assert property (@(posedge mclk) disable iff (rst)
      is_iret |=>
      pc_q == $past(stack_top_entry))
      else $error("interrupt return pc wrong");

   AST_RETL_ACC: assert property (@(posedge mclk) disable iff (rst)
      is_retl |=>
      acc_q == $past(lit))
      else $error("return literal not loaded");

   AST_READY_GAP: assert property (@(posedge mclk) disable iff (rst)
      !instr_ready |=>
      instr_ready)
      else $error("dead cycle too long");

   AST_FLUSH_HOLD: assert property (@(posedge mclk) disable iff (rst)
      state_q == MRD_FLUSH |=>
      acc_q == $past(acc_q) && pc_q == $past(pc_q) && !reg_wr && !reg_rd)
      else $error("word taken in dead cycle");

   AST_F2A_RD: assert property (@(posedge mclk) disable iff (rst)
      is_f2a |=>
      reg_rd && !reg_ext && !reg_wr && reg_addr == file_addr($past(instr)))
      else $error("file read strobe wrong");

   AST_E2A_OK: assert property (@(posedge mclk) disable iff (rst)
      is_e2a && !ext_below_floor(lit) |=>
      acc_q == $past(rd_data) && reg_rd && reg_ext && !ext_range_err)
      else $error("ext read lost");

   AST_A2E_ADDR: assert property (@(posedge mclk) disable iff (rst)
      is_a2e |=>
      reg_addr == $past(lit) && !reg_rd)
      else $error("ext write address wrong");

   AST_A2F_DATA: assert property (@(posedge mclk) disable iff (rst)
      is_a2f |=>
      reg_wdata == $past(acc_q) && !reg_rd)
      else $error("file write data wrong");

   AST_STROBE_EXCL: assert property (@(posedge mclk) disable iff (rst)
      !(reg_rd && reg_wr))
      else $error("read and write strobes together");

   AST_PC_STEP: assert property (@(posedge mclk) disable iff (rst)
      take && !is_ret |=>
      pc_q == $past(pc_q) + 1'b1)
      else $error("pc did not advance");

   AST_ERR_ONLY: assert property (@(posedge mclk) disable iff (rst)
      !is_e2a |=>
      !ext_range_err)
      else $error("range error without ext read");

   AST_IEN_CLEAR: assert property (@(posedge mclk) disable iff (rst)
      ien_clear && !is_iret |=>
      !global_interrupt_enable)
      else $error("interrupt enable not cleared");

   AST_PUSH_DROP: assert property (@(posedge mclk) disable iff (rst)
      is_ret && push |=>
      sp_q == $past(sp_q) - 3'h1)
      else $error("push beat the return");

   AST_L2A_QUIET: assert property (@(posedge mclk) disable iff (rst)
      is_l2a |=>
      !reg_wr && !reg_rd && !ext_range_err)
      else $error("literal move touched registers");

   AST_IDLE_HOLD: assert property (@(posedge mclk) disable iff (rst)
      take && instr == mrd_pkg::OP_IDLE_WORD && !push && !ien_clear |=>
      sp_q == $past(sp_q) && global_interrupt_enable == $past(global_interrupt_enable))
      else $error("idle touched stack or enable");
endmodule
`default_nettype wire

// ### mrd_regs.sv
// partner register file, read data follows the instruction address field
// assumes the write strobe arrives one cycle after the storing instruction
`timescale 1ns/1ps
`default_nettype none
module mrd_regs (
   // clock
   input  wire logic       mclk,
   // read side
   input  wire logic [7:0] rd_addr,
   output logic [7:0]      rd_data,
   // write side
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata
);
   logic [7:0] mem [256];
   // unwritten places stay unknown so a stray read cannot pass
   assign rd_data = mem[rd_addr];
   always_ff @(posedge mclk) begin
      if (reg_wr) mem[reg_addr] <= reg_wdata;
   end
endmodule
`default_nettype wire

// ### tb.sv
// testbench for the move and return decoder
// assumes the partner register file answers reads combinationally
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic mclk = 0, rst = 1, instr_valid = 0, push = 0, ien_clear = 0;
   logic [13:0] instr = 14'h0000;
   logic [10:0] push_addr = 11'h000;
   logic [10:0] pc;
   logic [7:0] reg_addr, reg_wdata, rd_data, acc;
   logic instr_ready, reg_ext, reg_rd, reg_wr, global_interrupt_enable, ext_range_err;
   int n_errors = 0, checks = 0;
   always #2.5 mclk = ~mclk;
   mrd_core dut (.mclk(mclk), .rst(rst), .instr(instr), .instr_valid(instr_valid),
      .instr_ready(instr_ready), .pc(pc), .reg_addr(reg_addr), .reg_ext(reg_ext),
      .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .rd_data(rd_data),
      .push(push), .push_addr(push_addr), .ien_clear(ien_clear),
      .global_interrupt_enable(global_interrupt_enable), .acc(acc),
      .ext_range_err(ext_range_err));
   mrd_regs u_regs (.mclk(mclk), .rd_addr(instr[7:0]), .rd_data(rd_data),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one word offered, taken at the next edge, results sampled mid cycle
   task automatic op(input logic [13:0] w);
      @(posedge mclk) begin instr <= w; instr_valid <= 1'b1; end
      @(posedge mclk) begin instr_valid <= 1'b0; instr <= 14'h0000; end
      @(negedge mclk);
   endtask
   task automatic t_moves();
      op(14'h195A);
      chk("acc", 8'h5A, acc);
      op(14'h0092);
      chk("strobe", {1'b1, 1'b0, 16'h125A}, {reg_wr, reg_ext, reg_addr, reg_wdata});
      op(14'h1E55);
      chk("strobe", {1'b1, 1'b1, 16'h555A}, {reg_wr, reg_ext, reg_addr, reg_wdata});
      op(14'h1900);
      op(14'h0812);
      chk("acc", 8'h5A, acc);
      chk("read", {1'b1, 1'b0, 8'h12}, {reg_rd, reg_ext, reg_addr});
      chk("file", 8'h5A, u_regs.mem[8'h12]);
      op(14'h1900);
      op(14'h1F55);
      chk("acc", 8'h5A, acc);
      chk("read", {1'b1, 1'b1, 8'h55}, {reg_rd, reg_ext, reg_addr});
      op(14'h1F10);
      chk("acc", 8'h5A, acc);
      chk("range", 1'b1, ext_range_err);
      $display("test moves done");
   endtask
   task automatic t_idle();
      logic [10:0] p;
      p = pc;
      op(mrd_pkg::OP_IDLE_WORD);
      chk("pc", p + 11'h001, pc);
      chk("idle", {8'h5A, 1'b0}, {acc, reg_wr});
      $display("test idle done");
   endtask
   task automatic t_returns();
      @(posedge mclk) begin push <= 1'b1; push_addr <= 11'h155; end
      @(posedge mclk) push_addr <= 11'h2AA;
      @(posedge mclk) begin push <= 1'b0; ien_clear <= 1'b1; end
      @(posedge mclk) ien_clear <= 1'b0;
      op(14'h1842);
      chk("acc", 8'h42, acc);
      chk("pc", 11'h2AA, pc);
      chk("ready", 1'b0, instr_ready);
      op(mrd_pkg::OP_INT_RET_WORD);
      chk("pc", 11'h155, pc);
      chk("enable", 1'b1, global_interrupt_enable);
      chk("ready", 1'b0, instr_ready);
      $display("test returns done");
   endtask
   // a word still offered in the dead cycle after a return must be ignored
   task automatic t_refuse();
      @(posedge mclk) begin
         push      <= 1'b1;
         push_addr <= 11'h123;
         ien_clear <= 1'b1;
      end
      @(posedge mclk) begin
         push        <= 1'b0;
         ien_clear   <= 1'b0;
         instr       <= 14'h1877;
         instr_valid <= 1'b1;
      end
      @(posedge mclk) instr <= 14'h1933;
      @(posedge mclk) begin
         instr_valid <= 1'b0;
         instr       <= 14'h0000;
      end
      @(negedge mclk);
      chk("acc", 8'h77, acc);
      chk("pc", 11'h123, pc);
      chk("ready", 1'b1, instr_ready);
      chk("enable", 1'b0, global_interrupt_enable);
      $display("test refuse done");
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      chk("reset", 20'h00000, {acc, pc, global_interrupt_enable});
      t_moves();
      t_idle();
      t_returns();
      t_refuse();
      end_sim();
   end
   // watchdog
   initial begin
      #20000;
      n_errors++;
      end_sim();
   end
endmodule
`default_nettype wire
